// file: hw/scpc_top.sv
// system clock prescaler with timed unlock, and pll control registers
// assumes a classic wishbone master on clk; analog pll outside
//
// Functional notes
// - unlock taken only with other bits zero
// - unlock clears after four cycles or select write
// - rewriting unlock neither extends nor clears it
// - division select writable while unlock open
// - reset select from divide-by-eight fuse
// - any select value writable after reset
// - codes zero to eight divide by powers two
// - status reserved bits read as zero
// - input halver passes or halves the source
// - pll on starts pll, rc with reference
// - lock reads one, clears with pll off
// - reference select picks prescaler or rc
// - usb halver passes or halves pll output
// - timer postscale off, one, 1.5, two
// - 1.5 division keeps average duty even
// - output select codes choose pll frequency
// - ratio change glitch free, no faster step
`timescale 1ns/1ps
`include "scpc_params.svh"

module scpc_top
    import scpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [ADDR_W-1:0] adr,
    input wire logic [3:0] sel,
    input wire logic [31:0] datIn,
    output logic [31:0] datOut,
    output logic ack,
    input wire logic divByEightFuse,
    input wire logic pllLockRaw,
    output scpc_pll_ctrl_type pllCtrl,
    output logic [3:0] divSelActive,
    output logic sysClkTick
);

    // reset release through two flops
    logic rstMeta_q;
    logic rstnSync_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstnSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstnSync_q <= rstMeta_q;
        end
    end

    // bus decode; data sits in the low byte lane
    logic reqTaken;
    logic wrLow;
    logic hitDiv;
    logic hitCsr;
    logic hitFrq;
    logic [7:0] wByte;
    assign reqTaken = cyc && stb && !ack;
    assign wrLow = reqTaken && we && sel[0];
    assign wByte = datIn[7:0];
    always_comb begin
        hitDiv = 1'b0;
        hitCsr = 1'b0;
        hitFrq = 1'b0;
        if (adr == ADDR_W'({`SCPC_IDX_DIVIDER, 2'b00})) begin
            hitDiv = 1'b1;
        end else if (adr == ADDR_W'({`SCPC_IDX_PLL_CSR, 2'b00})) begin
            hitCsr = 1'b1;
        end else if (adr == ADDR_W'({`SCPC_IDX_PLL_FRQ, 2'b00})) begin
            hitFrq = 1'b1;
        end
    end

    // register state
    logic unlock_q, unlock_d;
    logic [2:0] unlockCnt_q, unlockCnt_d;
    logic [3:0] divSel_q, divSel_d;
    logic strapDone_q, strapDone_d;
    logic pllOn_q, pllOn_d;
    logic halver_q, halver_d;
    logic locked_q, locked_d;
    scpc_frq_type frq_q, frq_d;
    logic ack_q, ack_d;
    logic [7:0] rdata_q, rdata_d;
    logic unlockReq;

    // unlock request only with every other bit zero
    assign unlockReq = wrLow && hitDiv && wByte[`SCPC_DIV_UNLOCK_BIT]
        && (wByte[6:0] == 7'h00);

    // next values of the software registers
    always_comb begin
        unlock_d = unlock_q;
        unlockCnt_d = unlockCnt_q;
        divSel_d = divSel_q;
        strapDone_d = 1'b1;
        pllOn_d = pllOn_q;
        halver_d = halver_q;
        frq_d = frq_q;
        ack_d = reqTaken;
        rdata_d = rdata_q;
        // fuse is a port, so it is caught after release, not in reset
        if (!strapDone_q) begin
            divSel_d = divByEightFuse ? `SCPC_DIV_SEL_FUSE
                                      : `SCPC_DIV_SEL_NOFUSE;
        end
        // window counts down; a rewrite does not touch it
        if (unlock_q) begin
            unlockCnt_d = unlockCnt_q - 3'h1;
            if (unlockCnt_q == 3'h1) begin
                unlock_d = 1'b0;
            end
        end
        if (unlockReq && !unlock_q) begin
            unlock_d = 1'b1;
            unlockCnt_d = `SCPC_UNLOCK_CYCLES;
        end
        // select write closes the window at once
        if (wrLow && hitDiv && unlock_q
            && !wByte[`SCPC_DIV_UNLOCK_BIT]) begin
            divSel_d = wByte[`SCPC_DIV_SEL_MSB:0];
            unlock_d = 1'b0;
        end
        if (wrLow && hitCsr) begin
            pllOn_d = wByte[`SCPC_CSR_ON_BIT];
            halver_d = wByte[`SCPC_CSR_HALVER_BIT];
        end
        if (wrLow && hitFrq) begin
            frq_d = scpc_frq_type'(wByte);
        end
        // read data captured with the answer
        if (reqTaken) begin
            rdata_d = 8'h00;
            if (hitDiv) begin
                rdata_d = {unlock_q, 3'b000, divSel_q};
            end else if (hitCsr) begin
                rdata_d = {3'b000, halver_q, 2'b00,
                           pllOn_q, locked_q};
            end else if (hitFrq) begin
                rdata_d = frq_q;
            end
        end
    end

    // lock is sticky until pll is switched off; writes never reach it
    always_comb begin
        locked_d = locked_q;
        if (!pllOn_q) begin
            locked_d = 1'b0;
        end else if (pllLockRaw) begin
            locked_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
            unlock_q <= 1'b0;
            unlockCnt_q <= 3'h0;
            divSel_q <= `SCPC_DIV_SEL_NOFUSE;
            strapDone_q <= 1'b0;
            pllOn_q <= 1'b0;
            halver_q <= 1'b0;
            locked_q <= 1'b0;
            frq_q <= scpc_frq_type'(`SCPC_FRQ_RESET);
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            unlock_q <= unlock_d;
            unlockCnt_q <= unlockCnt_d;
            divSel_q <= divSel_d;
            strapDone_q <= strapDone_d;
            pllOn_q <= pllOn_d;
            halver_q <= halver_d;
            locked_q <= locked_d;
            frq_q <= frq_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign ack = ack_q;
    assign datOut = {24'h00_0000, rdata_q};

    // prescaler: ratio switches only at the end of a full old period,
    // so no period is shorter than either the old or the new one
    logic [3:0] active_q, active_d;
    logic [7:0] divCnt_q, divCnt_d;
    logic tick_q, tick_d;
    logic [7:0] terminal;
    assign terminal = 8'((9'h001 << active_q) - 9'h001);
    always_comb begin
        active_d = active_q;
        divCnt_d = divCnt_q + 8'h01;
        tick_d = 1'b0;
        if (divCnt_q == terminal) begin
            divCnt_d = 8'h00;
            tick_d = 1'b1;
            // reserved codes keep the ratio already running
            if (divSel_q <= `SCPC_DIV_SEL_MAX) begin
                active_d = divSel_q;
            end
        end
    end
    always_ff @(posedge clk or negedge rstnSync_q) begin
        if (!rstnSync_q) begin
            active_q <= `SCPC_DIV_SEL_NOFUSE;
            divCnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            active_q <= active_d;
            divCnt_q <= divCnt_d;
            tick_q <= tick_d;
        end
    end
    assign sysClkTick = tick_q;
    assign divSelActive = active_q;

    // control levels to the analog side
    always_comb begin
        pllCtrl.pllOn = pllOn_q;
        pllCtrl.pllInputHalver = halver_q;
        pllCtrl.rcOscForceOn = pllOn_q && frq_q.pllReferenceSelect;
        // 1.5 ratio is built in the pll clock domain with even duty
        pllCtrl.timerClkConnected =
            (frq_q.timerPostscaleSelect != TIMER_OFF);
        pllCtrl.frq = frq_q;
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstnSync_q);

    a_unlock_refused: assert property (
        wrLow && hitDiv && wByte[7] && (wByte[6:0] != 7'h00) && !unlock_q
        |=> !unlock_q) else $error("unlock taken with nonzero bits");
    a_unlock_expiry: assert property (
        $rose(unlock_q) |-> ##[1:4] !unlock_q)
        else $error("unlock window outlived four cycles");
    a_unlock_norestart: assert property (
        unlock_q [*4] |=> !unlock_q)
        else $error("unlock window was extended");
    a_divsel_write: assert property (
        wrLow && hitDiv && unlock_q && !wByte[7]
        |=> divSel_q == $past(wByte[3:0]) && !unlock_q)
        else $error("select write not applied");
    a_fuse_load: assert property (
        $rose(strapDone_q) |-> divSel_q == ($past(divByEightFuse) ? 4'h3
        : 4'h0)) else $error("fuse reset value wrong");
    a_ratio_one: assert property (
        tick_q && active_q == 4'h0 && divSel_q == 4'h0 |=> tick_q)
        else $error("divide by one missed a tick");
    a_ratio_glitch: assert property (
        !tick_q |-> $stable(active_q))
        else $error("ratio changed mid period");
    a_csr_reserved: assert property (
        reqTaken && hitCsr |=> rdata_q[7:5] == 3'b000 && rdata_q[3:2] == 2'b00)
        else $error("reserved status bits not zero");
    a_lock_clear: assert property (
        !pllOn_q |=> !locked_q) else $error("lock held with pll off");
    a_lock_hold: assert property (
        locked_q && pllOn_q |=> locked_q)
        else $error("lock dropped while pll on");
    a_rc_force: assert property (
        wrLow && hitCsr && wByte[`SCPC_CSR_ON_BIT]
        && frq_q.pllReferenceSelect |=> pllCtrl.rcOscForceOn)
        else $error("rc oscillator not forced on");

endmodule

// file: shared/scpc_params.svh
// offsets, field positions, reset values and timing counts of the
// clock control block; included by the top module and the bench
`ifndef SCPC_PARAMS_SVH
`define SCPC_PARAMS_SVH

// register indexes; byte address is four times the index
`define SCPC_IDX_DIVIDER 8'h30
`define SCPC_IDX_PLL_CSR 8'h31
`define SCPC_IDX_PLL_FRQ 8'h32

// system_clock_divider fields
`define SCPC_DIV_UNLOCK_BIT 7
`define SCPC_DIV_SEL_MSB 3
`define SCPC_DIV_SEL_FUSE 4'h3
`define SCPC_DIV_SEL_NOFUSE 4'h0
`define SCPC_DIV_SEL_MAX 4'h8

// pll_control_status fields
`define SCPC_CSR_HALVER_BIT 4
`define SCPC_CSR_ON_BIT 1
`define SCPC_CSR_LOCK_BIT 0

// pll_frequency_control reset value
`define SCPC_FRQ_RESET 8'h04

// unlock window length in master clock cycles
`define SCPC_UNLOCK_CYCLES 3'h4

`endif

// file: shared/scpc_pkg.sv
// types shared by the clock control block and its bench
// assumes scpc_params.svh sits beside it on the include path
package scpc_pkg;

    // high-speed timer postscaler codes
    typedef enum logic [1:0] {
        TIMER_OFF,
        TIMER_DIV1,
        TIMER_DIV1P5,
        TIMER_DIV2
    } scpc_timer_post_type;

    // pll_frequency_control layout, bit 7 down to bit 0
    typedef struct packed {
        logic pllReferenceSelect;
        logic usbClockHalver;
        scpc_timer_post_type timerPostscaleSelect;
        logic [3:0] pllOutputSelect;
    } scpc_frq_type;

    // control levels driven to the analog pll and oscillators
    typedef struct packed {
        logic pllOn;
        logic pllInputHalver;
        logic rcOscForceOn;
        logic timerClkConnected;
        scpc_frq_type frq;
    } scpc_pll_ctrl_type;

endpackage

// file: tb/scpc_top_bench.sv
// self-checking bench for the clock control block, random plus corners
// assumes one ack per wishbone request; the bench drives the fuse level
`timescale 1ns/1ps
`include "scpc_params.svh"

module scpc_top_bench
    import scpc_pkg::*;
;
    localparam logic [7:0] ADIV = 8'(`SCPC_IDX_DIVIDER * 4);
    localparam logic [7:0] ACSR = 8'(`SCPC_IDX_PLL_CSR * 4);
    localparam logic [7:0] AFRQ = 8'(`SCPC_IDX_PLL_FRQ * 4);
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic fuse = 1'b1;
    logic lockRaw = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datIn = 32'h0000_0000;
    logic [31:0] datOut;
    logic [31:0] rd;
    logic ack;
    logic tick;
    logic [3:0] divAct;
    scpc_pll_ctrl_type pllCtrl;
    logic [3:0] pll_output_select [7] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA};
    int numErrors = 0;
    int nCompared = 0;
    int seedVal;

    // free-running master clock, 8 ns period
    always begin
        #4 clk = ~clk;
    end

    scpc_top DUT (.clk(clk), .rstn(rstn), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .datIn(datIn), .datOut(datOut), .ack(ack),
        .divByEightFuse(fuse), .pllLockRaw(lockRaw), .pllCtrl(pllCtrl),
        .divSelActive(divAct), .sysClkTick(tick));

    // expected tick period for a select code
    function automatic logic [31:0] ratio(input logic [3:0] c);
        return 32'h0000_0001 << c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic timedOut();
        numErrors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        results();
    endtask

    // one classic cycle; ack and data taken at the same edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] dv, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        datIn <= {24'h00_0000, dv};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) timedOut();
        rd = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        wb(1'b1, a, dv, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00, 4'hF);
        check(rd, exp);
    endtask

    // unlock then select, second write lands inside the window
    task automatic setDiv(input logic [3:0] c);
        wr(ADIV, 8'h80);
        wr(ADIV, {4'h0, c});
    endtask

    // bounded wait for the next prescaler tick, n counts cycles
    task automatic waitTick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 600);
        if (n >= 600) timedOut();
    endtask

    initial begin
        int n;
        logic [3:0] c;
        logic [7:0] d;
        seedVal = $urandom(45);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(ADIV, 32'h0000_0003);
        rdc(ACSR, 32'h0000_0000);
        rdc(AFRQ, 32'h0000_0004);
        $display("reset values done");
        // unlock opens only with clean byte and closes by itself
        wr(ADIV, 8'h80);
        rdc(ADIV, 32'h0000_0083);
        rdc(ADIV, 32'h0000_0003);
        wr(ADIV, 8'h81);
        wr(ADIV, 8'h05);
        rdc(ADIV, 32'h0000_0003);
        wr(ADIV, 8'h80);
        wr(ADIV, 8'h80);
        wr(ADIV, 8'h05);
        rdc(ADIV, 32'h0000_0003);
        $display("unlock window done");
        // corners 8 and 0, then random legal codes
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 4'h8 : (i == 1) ? 4'h0 : 4'($urandom_range(8));
            setDiv(c);
            rdc(ADIV, {28'h000_0000, c});
            waitTick(n);
            waitTick(n);
            waitTick(n);
            check(32'(n), ratio(c));
            check({28'h000_0000, divAct}, {28'h000_0000, c});
        end
        setDiv(4'h9);
        rdc(ADIV, 32'h0000_0009);
        waitTick(n);
        waitTick(n);
        check(32'(n), ratio(c));
        $display("division codes done");
        // lock needs pll on, holds, clears only with pll off
        lockRaw <= 1'b1;
        rdc(ACSR, 32'h0000_0000);
        // halver settles before the pll is switched on
        wr(ACSR, 8'h10);
        check({31'h0, pllCtrl.pllOn}, 32'h0000_0000);
        wr(ACSR, 8'hFF);
        check({31'h0, pllCtrl.pllInputHalver}, 32'h0000_0001);
        check({31'h0, pllCtrl.pllOn}, 32'h0000_0001);
        rdc(ACSR, 32'h0000_0013);
        lockRaw <= 1'b0;
        rdc(ACSR, 32'h0000_0013);
        wr(ACSR, 8'h01);
        rdc(ACSR, 32'h0000_0000);
        check({31'h0, pllCtrl.pllInputHalver}, 32'h0000_0000);
        $display("pll status done");
        // frequency fields drive the pll selects, every timer code
        wr(ACSR, 8'h02);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[7] = i[0];
            d[5:4] = 2'(i);
            d[3:0] = pll_output_select[i % 7];
            wr(AFRQ, d);
            rdc(AFRQ, {24'h00_0000, d});
            check({pllCtrl.rcOscForceOn, pllCtrl.timerClkConnected,
                pllCtrl.frq}, {d[7], d[5:4] != 2'b00, d});
        end
        // pll off ahead of power-down stops the rc oscillator
        wr(ACSR, 8'h00);
        check({31'h0, pllCtrl.rcOscForceOn}, 32'h0000_0000);
        // enable with the rc reference already picked
        wr(ACSR, 8'h02);
        check({31'h0, pllCtrl.rcOscForceOn}, 32'h0000_0001);
        // preferred setup: 96MHz, timer by 1.5, usb by 2
        d = 8'h6A;
        wr(AFRQ, d);
        check({24'h00_0000, pllCtrl.frq}, {24'h00_0000, d});
        check({31'h0, pllCtrl.rcOscForceOn}, 32'h0000_0000);
        wr(ACSR, 8'h00);
        $display("frequency control done");
        // unmapped place and a write without the low byte enable
        wr(8'hD0, 8'h55);
        rdc(8'hD0, 32'h0000_0000);
        wb(1'b1, AFRQ, 8'h00, 4'h2);
        rdc(AFRQ, {24'h00_0000, d});
        $display("bus refusals done");
        // second reset in mid-run with the fuse unprogrammed
        fuse <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(ADIV, 32'h0000_0000);
        rdc(AFRQ, 32'h0000_0004);
        check({31'h0, pllCtrl.pllOn}, 32'h0000_0000);
        waitTick(n);
        waitTick(n);
        check(32'(n), 32'h0000_0001);
        check({28'h000_0000, divAct}, 32'h0000_0000);
        $display("second reset done");
        results();
    end
endmodule
